// ===== pkg/rsc_defines.svh
// Register offsets, field positions, reset values and constants of the root control page.
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RSC_OFF_FEATURE_ID   12'h000
`define RSC_OFF_IMPL_ID      12'h008
`define RSC_OFF_CONTROL      12'h020
`define RSC_OFF_CONTROL_ACK  12'h024

// ****************************************************************
// Field positions
// ****************************************************************
`define RSC_FID_REALM_IDX_HI 31
`define RSC_FID_REALM_IDX_LO 22
`define RSC_FID_REALM_BIT    3
`define RSC_FID_REGPA_BIT    2
`define RSC_FID_BCAST_BIT    1
`define RSC_FID_ROOT_BIT     0
`define RSC_CTL_GPC_BIT      1
`define RSC_CTL_ACC_BIT      0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RSC_CTL_RESET        2'h0
`define RSC_ACK_RESET        2'h0
`define RSC_REALM_BASE       32'h0002_0000
`define RSC_REALM_STEP       32'h0001_0000
`define RSC_ZERO_WORD        32'h0000_0000

`endif

// ===== pkg/rsc_pkg.sv
// Types shared by the root control page and its update sequencer.
package rsc_pkg;

	// Update sequencer states.
	typedef enum logic [1:0]
	{
		UPD_IDLE,
		UPD_SETTLE,
		UPD_WAIT
	} rsc_upd_e;

	// Drain and completion levels reported by the translation datapath.
	typedef struct packed
	{
		logic uncheckedIdle;
		logic faultsRecorded;
		logic tableFetchIdle;
		logic clientObservable;
		logic internalIdle;
		logic terminateMarked;
	} rsc_drain_s;

	// Gating levels driven into the translation datapath.
	typedef struct packed
	{
		logic checkAll;
		logic blockAccess;
		logic tableFetchAllow;
		logic granuleFaultAll;
	} rsc_gate_s;

endpackage

// ===== hw/rsc_update_seq.sv
// One enable/acknowledge update sequencer: copies the control bit into its acknowledge bit.
`include "rsc_defines.svh"

module rsc_update_seq
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic clkEn,
	// Control bit and completion conditions
	input  wire logic req,
	input  wire logic upReady,
	input  wire logic downReady,
	// Acknowledge
	output logic      ack,
	output logic      busy
);

	rsc_pkg::rsc_upd_e state;
	rsc_pkg::rsc_upd_e next_state;
	logic              readyNow;
	logic              done;

	assign readyNow = req ? upReady : downReady;
	assign done     = (state == rsc_pkg::UPD_WAIT) && readyNow;
	assign busy     = (state != rsc_pkg::UPD_IDLE) || (req != ack);

	// The settle step gives the datapath one cycle to see the new control
	// level before its idle levels are trusted.
	always_comb
	begin
		next_state = state;
		case (state)
			rsc_pkg::UPD_IDLE:   if (req != ack) next_state = rsc_pkg::UPD_SETTLE;
			rsc_pkg::UPD_SETTLE: next_state = rsc_pkg::UPD_WAIT;
			rsc_pkg::UPD_WAIT:   if (readyNow) next_state = rsc_pkg::UPD_IDLE;
			default:             next_state = rsc_pkg::UPD_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= rsc_pkg::UPD_IDLE;
			ack   <= 1'b0;
		end
		else if (clkEn)
		begin
			state <= next_state;
			if (done)
				ack <= req; // [RULE12] [RULE19]
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	ack_copies_req_a: assert property ($changed(ack) |-> ack == $past(req) && $past(done)) // [RULE12]
		else $error("acknowledge changed without a completed update");
	up_guarded_a: assert property ($rose(ack) |-> $past(upReady)) // [RULE13]
		else $error("acknowledge rose before up completion");
	down_guarded_a: assert property ($fell(ack) |-> $past(downReady)) // [RULE14]
		else $error("acknowledge fell before down completion");

endmodule // rsc_update_seq

// ===== hw/rsc_root_ctrl.sv
// Root control page: feature and implementation identification, control and acknowledge.
//
// Functional notes
// (RULE1) With realm interface present, bits 31:22 give page index; offset 0x20000+idx*0x10000.
// (RULE2) Bit 0 of the realm page index always reads zero, 128KB aligned.
// (RULE3) Bit 3 reports realm programming interface presence.
// (RULE4) Bit 2 reports register based physical address invalidation presence.
// (RULE5) Without broadcast invalidation, register based invalidation is always present.
// (RULE6) Bit 1 reports acceptance of broadcast physical address invalidation.
// (RULE7) Bit 0 of feature identification is read-only one.
// (RULE8) Accesses without root privilege read zero and ignore writes.
// (RULE9) Implementation id holds product, variant and revision codes, read-only.
// (RULE10) Maker code: continuation in 11:8, bit 7 zero, identity in 6:0.
// (RULE11) Granule check enable zero bypasses checks; one checks all but table walks.
// (RULE12) Granule check acknowledge copies enable once its guarantees hold.
// (RULE13) Rising check enable acknowledged after unchecked traffic has drained.
// (RULE14) Falling check enable acknowledged after faults recorded and table fetches done.
// (RULE15) Old table configuration drains only after a later all-address invalidation.
// (RULE16) Both enable bits reset to zero.
// (RULE17) Enable bits are read-only while either differs from its acknowledge.
// (RULE18) Access enable zero blocks all accesses and outranks check enable.
// (RULE19) Access acknowledge copies enable once its guarantees hold.
// (RULE20) Rising access enable acknowledged after pending terminations are marked.
// (RULE21) Falling access enable acknowledged after client and internal traffic completes.
// (RULE22) While disabled, client accesses behave as granule faults.
// (RULE23) Read-only acknowledge register: bit 1 check, bit 0 access, reset zero.
//
// The APB slave port was chosen for this implementation.
`include "rsc_defines.svh"

module rsc_root_ctrl
#(
	// Feature straps.
	parameter logic       REALM_PRESENT   = 1'b1,
	parameter logic [9:0] REALM_PAGE_IDX  = 10'h002,
	parameter logic       REG_PA_INVAL    = 1'b0,
	parameter logic       BCAST_PA_INVAL  = 1'b1,
	// Identification codes; all values are arbitrary.
	parameter logic [11:0] PRODUCT_CODE   = 12'h001,
	parameter logic [3:0]  VARIANT_CODE   = 4'h0,
	parameter logic [3:0]  REVISION_CODE  = 4'h0,
	parameter logic [3:0]  MAKER_CONT     = 4'h0,
	parameter logic [6:0]  MAKER_IDENT    = 7'h01
)
(
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                reset_n,
	input  wire logic                clkEn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	input  wire logic                rootAccess,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	// Datapath handshake
	input  wire rsc_pkg::rsc_drain_s drain,
	input  wire logic                allPhysInvalDone,
	output rsc_pkg::rsc_gate_s       gate,
	output logic                     oldCfgMayLinger
);

	// ****************************************************************
	// Feature and identification words
	// ****************************************************************
	logic [31:0] featureWord;
	logic [31:0] implWord;
	logic [9:0]  realmIdx;
	logic        regPaEff;

	assign realmIdx = REALM_PRESENT ? {REALM_PAGE_IDX[9:1], 1'b0} : 10'h000; // [RULE1] [RULE2]
	assign regPaEff = REG_PA_INVAL | ~BCAST_PA_INVAL; // [RULE5]

	assign featureWord = {realmIdx,                                // [RULE1]
	                      18'h0_0000,
	                      REALM_PRESENT,                           // [RULE3]
	                      regPaEff,                                // [RULE4]
	                      BCAST_PA_INVAL,                          // [RULE6]
	                      1'b1};                                   // [RULE7]

	assign implWord = {PRODUCT_CODE, VARIANT_CODE, REVISION_CODE, // [RULE9]
	                   MAKER_CONT, 1'b0, MAKER_IDENT};             // [RULE10]

	// ****************************************************************
	// Control state
	// ****************************************************************
	logic        granule_check_enable;
	logic        accEn;
	logic        gpcAck;
	logic        accAck;
	logic        gpcBusy;
	logic        accBusy;
	logic [31:0] ctrlWord;
	logic [31:0] ackWord;

	assign ctrlWord = {30'h0000_0000, granule_check_enable, accEn};
	assign ackWord  = {30'h0000_0000, gpcAck, accAck}; // [RULE23]

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic        setupPhase;
	logic        accessPhase;
	logic        hitFeature;
	logic        hitImpl;
	logic        hitCtrl;
	logic        hitAck;
	logic        hitAny;
	logic [31:0] readData;
	logic        decodeErr;
	logic        ctrlWritable;
	logic        ctrlWrite;

	assign setupPhase  = psel && !penable;
	assign accessPhase = psel && penable;
	assign hitFeature  = paddr == `RSC_OFF_FEATURE_ID;
	assign hitImpl     = paddr == `RSC_OFF_IMPL_ID;
	assign hitCtrl     = paddr == `RSC_OFF_CONTROL;
	assign hitAck      = paddr == `RSC_OFF_CONTROL_ACK;
	assign hitAny      = hitFeature || hitImpl || hitCtrl || hitAck;

	// Without root privilege every register reads as zero, mapped or not.
	assign readData = !rootAccess ? `RSC_ZERO_WORD :             // [RULE8]
	                  hitFeature  ? featureWord :
	                  hitImpl     ? implWord :
	                  hitCtrl     ? ctrlWord :
	                  hitAck      ? ackWord : `RSC_ZERO_WORD;

	// Only root accesses to holes are reported as errors.
	assign decodeErr = rootAccess && !hitAny;

	// Both enables stay frozen until the previous update has completed.
	assign ctrlWritable = (granule_check_enable == gpcAck) && (accEn == accAck) // [RULE17]
	                      && !gpcBusy && !accBusy;
	assign ctrlWrite    = clkEn && accessPhase && pwrite && hitCtrl && rootAccess // [RULE8]
	                      && pstrb[0] && ctrlWritable;            // [RULE17]

	// Zero wait states; freezing the clock enable also stalls the bus.
	assign pready = clkEn;

	// Read data and error are captured in the setup cycle so that both come
	// from flip-flops; the word is one cycle plus any clock enable stall cycles older than the accepting edge.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata  <= `RSC_ZERO_WORD;
			pslverr <= 1'b0;
		end
		else if (clkEn && setupPhase)
		begin
			prdata  <= pwrite ? `RSC_ZERO_WORD : readData;
			pslverr <= decodeErr;
		end
	end

	// ****************************************************************
	// Control register
	// ****************************************************************
	localparam logic [1:0] CTL_RESET = `RSC_CTL_RESET;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			granule_check_enable <= CTL_RESET[`RSC_CTL_GPC_BIT]; // [RULE16]
			accEn <= CTL_RESET[`RSC_CTL_ACC_BIT]; // [RULE16]
		end
		else if (ctrlWrite)
		begin
			granule_check_enable <= pwdata[`RSC_CTL_GPC_BIT];
			accEn <= pwdata[`RSC_CTL_ACC_BIT];
		end
	end

	// ****************************************************************
	// Update completion conditions
	// ****************************************************************
	logic gpcUpReady;
	logic gpcDownReady;
	logic accUpReady;
	logic accDownReady;

	assign gpcUpReady   = drain.uncheckedIdle;                          // [RULE13]
	assign gpcDownReady = drain.faultsRecorded && drain.tableFetchIdle; // [RULE14]
	assign accUpReady   = drain.terminateMarked;                        // [RULE20]
	assign accDownReady = drain.clientObservable && drain.internalIdle  // [RULE21]
	                      && drain.tableFetchIdle;

	rsc_update_seq u_gpc_seq
	(
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.clkEn     (clkEn),
		.req       (granule_check_enable),
		.upReady   (gpcUpReady),
		.downReady (gpcDownReady),
		.ack       (gpcAck),
		.busy      (gpcBusy)
	);

	rsc_update_seq u_acc_seq
	(
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.clkEn     (clkEn),
		.req       (accEn),
		.upReady   (accUpReady),
		.downReady (accDownReady),
		.ack       (accAck),
		.busy      (accBusy)
	);

	// ****************************************************************
	// Datapath gating
	// ****************************************************************
	// New accesses follow the written value at once; the acknowledge only
	// reports when the older traffic has been dealt with.
	assign gate.blockAccess     = !accEn;          // [RULE18]
	assign gate.checkAll        = accEn && granule_check_enable;  // [RULE11] [RULE18]
	assign gate.tableFetchAllow = accEn;           // [RULE21]
	assign gate.granuleFaultAll = !accEn;          // [RULE22]

	// ****************************************************************
	// Old configuration tracking
	// ****************************************************************
	logic gpcAckPrev;
	logic gpcAckFall;

	// The acknowledge level of the previous cycle exposes the cycle in which
	// a 1-to-0 check update has just completed.
	assign gpcAckFall = clkEn && gpcAckPrev && !gpcAck;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			gpcAckPrev <= 1'b0;
		else if (clkEn)
			gpcAckPrev <= gpcAck;
	end

	// A completed 1-to-0 check update leaves old-table traffic possibly in
	// flight until an all-address invalidation completes; a new fall wins
	// over a clear in the same cycle.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			oldCfgMayLinger <= 1'b0;
		else if (gpcAckFall)
			oldCfgMayLinger <= 1'b1;  // [RULE15]
		else if (clkEn && allPhysInvalDone)
			oldCfgMayLinger <= 1'b0;  // [RULE15]
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence rootRead(logic hit);
		clkEn && setupPhase && !pwrite && rootAccess && hit;
	endsequence

	sequence guestAccess;
		clkEn && setupPhase && !rootAccess;
	endsequence

	sequence blockedWrite;
		clkEn && accessPhase && pwrite && hitCtrl && !ctrlWritable;
	endsequence

	sequence gpcStart;
		ctrlWrite && pwdata[`RSC_CTL_GPC_BIT] != granule_check_enable;
	endsequence

	sequence accStart;
		ctrlWrite && pwdata[`RSC_CTL_ACC_BIT] != accEn;
	endsequence

	feature_word_a: assert property (rootRead(hitFeature) |=> // [RULE7]
		prdata[0] && (prdata[2] || prdata[1]) && !prdata[22] && prdata[21:4] == 18'h0_0000)
		else $error("feature word malformed");
	realm_field_a: assert property (rootRead(hitFeature) |=> // [RULE1]
		prdata[3] || prdata[31:22] == 10'h000)
		else $error("realm index shown without realm interface");
	impl_word_a: assert property (rootRead(hitImpl) |=> // [RULE10]
		!prdata[7] && prdata[31:20] == PRODUCT_CODE)
		else $error("implementation word malformed");
	guest_raz_a: assert property (guestAccess ##0 !pwrite |=> prdata == `RSC_ZERO_WORD) // [RULE8]
		else $error("non-root read returned data");
	guest_wi_a: assert property (clkEn && accessPhase && pwrite && !rootAccess |=> // [RULE8]
		$stable(granule_check_enable) && $stable(accEn))
		else $error("non-root write changed control");
	ctrl_locked_a: assert property (blockedWrite |=> $stable(granule_check_enable) && $stable(accEn)) // [RULE17]
		else $error("control changed during an update");
	ctrl_write_a: assert property (ctrlWrite |=> granule_check_enable == $past(pwdata[1]) && // [RULE17]
		accEn == $past(pwdata[0]))
		else $error("permitted control write lost");
	reset_clear_a: assert property ($rose(reset_n) |-> !granule_check_enable && !accEn && !gpcAck && !accAck) // [RULE16]
		else $error("control not clear after reset");
	access_priority_a: assert property (!accEn |-> !gate.checkAll && gate.blockAccess // [RULE18]
		&& gate.granuleFaultAll && !gate.tableFetchAllow)
		else $error("disabled access not blocking");
	ack_register_a: assert property (rootRead(hitAck) |=> // [RULE23]
		prdata == {30'h0000_0000, $past(gpcAck), $past(accAck)})
		else $error("acknowledge register mismatch");
	linger_set_a: assert property (gpcAckFall |=> oldCfgMayLinger) // [RULE15]
		else $error("old configuration flag not raised");

	// Update handshake: an accepted change holds its acknowledge through the
	// settle and first wait cycles and locks the register until it completes.
	gpc_settle_a: assert property (gpcStart |=> $stable(gpcAck) [*3]) // [RULE13] [RULE14]
		else $error("check acknowledge moved before the update settled");
	acc_settle_a: assert property (accStart |=> $stable(accAck) [*3]) // [RULE20] [RULE21]
		else $error("access acknowledge moved before the update settled");
	gpc_lock_a: assert property (gpcStart |=> !ctrlWritable) // [RULE17]
		else $error("control writable during a check update");
	acc_lock_a: assert property (accStart |=> !ctrlWritable) // [RULE17]
		else $error("control writable during an access update");
	linger_clear_a: assert property (clkEn && allPhysInvalDone && !gpcAckFall |=> // [RULE15]
		!oldCfgMayLinger)
		else $error("old configuration flag survived an invalidation");
	check_bypass_a: assert property (!granule_check_enable |-> !gate.checkAll) // [RULE11]
		else $error("checks applied while disabled");

	// Privilege, control readback and identification.
	guest_no_err_a: assert property (guestAccess |=> !pslverr) // [RULE8]
		else $error("non-root access reported an error");
	ctrl_read_a: assert property (rootRead(hitCtrl) |=> // [RULE16]
		prdata == {30'h0000_0000, $past(granule_check_enable), $past(accEn)})
		else $error("control register read mismatch");
	impl_fields_a: assert property (rootRead(hitImpl) |=> // [RULE9]
		prdata[19:12] == {VARIANT_CODE, REVISION_CODE} && prdata[11:8] == MAKER_CONT
		&& prdata[6:0] == MAKER_IDENT)
		else $error("implementation fields mismatch");
	realm_page_a: assert property (rootRead(hitFeature) |=> // [RULE2]
		!prdata[3] || prdata[31:23] == REALM_PAGE_IDX[9:1])
		else $error("realm page index mismatch");

endmodule // rsc_root_ctrl

// ===== test/rsc_root_ctrl_tb.sv
// Self-checking testbench of the root control page: identification, privilege, control updates.
`include "rsc_defines.svh"

`define CHK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("BAD %0t got %h expected %h", $time, (got), (exp)); \
		end \
	end

module rsc_root_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Straps and signals
	// ****************************************************************
	// Identification values are arbitrary.
	localparam logic       REALM = 1'b1;
	localparam logic [9:0] IDX   = 10'h3FF;
	localparam logic       REGPA = 1'b0;
	localparam logic       BCAST = 1'b0;
	localparam logic [31:0] IID_EXP = 32'hA5C3_977F;

	logic                    core_clk;
	logic                    reset_n;
	logic                    clkEn;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [11:0]             paddr;
	logic [31:0]             pwdata;
	logic [3:0]              pstrb;
	logic                    rootAccess;
	logic                    pready;
	logic [31:0]             prdata;
	logic                    pslverr;
	rsc_pkg::rsc_drain_s     drain;
	logic                    allPhysInvalDone;
	rsc_pkg::rsc_gate_s      gate;
	logic                    oldCfgMayLinger;
	logic [1:0]              ctlv;
	logic [1:0]              ackv;
	int                      err_total;
	int                      checks;

	rsc_root_ctrl #(
		.REALM_PRESENT  (REALM),
		.REALM_PAGE_IDX (IDX),
		.REG_PA_INVAL   (REGPA),
		.BCAST_PA_INVAL (BCAST),
		.PRODUCT_CODE   (12'hA5C),
		.VARIANT_CODE   (4'h3),
		.REVISION_CODE  (4'h9),
		.MAKER_CONT     (4'h7),
		.MAKER_IDENT    (7'h7F)
	) i_rsc_root_ctrl (
		.core_clk         (core_clk),
		.reset_n          (reset_n),
		.clkEn            (clkEn),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.pstrb            (pstrb),
		.rootAccess       (rootAccess),
		.pready           (pready),
		.prdata           (prdata),
		.pslverr          (pslverr),
		.drain            (drain),
		.allPhysInvalDone (allPhysInvalDone),
		.gate             (gate),
		.oldCfgMayLinger  (oldCfgMayLinger)
	);

	always #10ns core_clk = ~core_clk;

	// ****************************************************************
	// Expectations
	// ****************************************************************
	function automatic logic [31:0] fid_exp();
		return {REALM ? (IDX & 10'h3FE) : 10'h000, 18'h0_0000, REALM, REGPA | ~BCAST, BCAST, 1'b1};
	endfunction

	function automatic logic [31:0] rd_exp(input logic [11:0] a, input logic root);
		if (!root)
			return 32'h0000_0000;
		case (a)
			`RSC_OFF_FEATURE_ID:  return fid_exp();
			`RSC_OFF_IMPL_ID:     return IID_EXP;
			`RSC_OFF_CONTROL:     return {30'h0000_0000, ctlv};
			`RSC_OFF_CONTROL_ACK: return {30'h0000_0000, ackv};
			default:              return 32'h0000_0000;
		endcase
	endfunction

	function automatic rsc_pkg::rsc_gate_s gate_exp(input logic [1:0] v);
		return rsc_pkg::rsc_gate_s'({v[1] & v[0], ~v[0], v[0], ~v[0]});
	endfunction

	// ****************************************************************
	// Bus master and closing
	// ****************************************************************
	// The access phase is stretched at random by holding the clock enable low.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic root, output logic [31:0] rd, output logic er);
		int stall;
		int n;
		stall = $urandom_range(0, 2);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= {3'($urandom), 1'b1};
		rootAccess <= root;
		@(posedge core_clk);
		penable <= 1'b1;
		clkEn <= (stall == 0);
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
			if (stall > 0 && n >= stall)
				clkEn <= 1'b1;
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic root);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0000_0000, root, rd, er);
		`CHK(rd, rd_exp(a, root));
		`CHK(er, 1'b0);
	endtask

	// One control update: the named drain levels are held low, then released.
	task automatic upd(input logic [1:0] v, input logic [5:0] need);
		logic [31:0] rd;
		logic er;
		int n;
		drain <= rsc_pkg::rsc_drain_s'(~need);
		apb(1'b1, `RSC_OFF_CONTROL, {30'h0000_0000, v}, 1'b1, rd, er);
		ctlv = v;
		@(negedge core_clk);
		`CHK(gate, gate_exp(v));
		repeat (6) @(posedge core_clk);
		rd_chk(`RSC_OFF_CONTROL_ACK, 1'b1);
		apb(1'b1, `RSC_OFF_CONTROL, {30'h0000_0000, ~v}, 1'b1, rd, er);
		rd_chk(`RSC_OFF_CONTROL, 1'b1);
		drain <= rsc_pkg::rsc_drain_s'(6'h3F);
		n = 0;
		do
		begin
			apb(1'b0, `RSC_OFF_CONTROL_ACK, 32'h0000_0000, 1'b1, rd, er);
			n++;
		end
		while (rd[1:0] !== v && n < 10);
		ackv = v;
		`CHK(rd, {30'h0000_0000, v});
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial
	begin
		#200us;
		err_total++;
		print_verdict();
	end

	initial
	begin
		logic [31:0] rd;
		logic er;
		logic [11:0] a;
		logic root;
		logic wr;
		core_clk = 1'b0;
		reset_n = 1'b0;
		clkEn = 1'b1;
		{psel, penable, pwrite, rootAccess} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		drain = rsc_pkg::rsc_drain_s'(6'h3F);
		allPhysInvalDone = 1'b0;
		ctlv = 2'h0;
		ackv = 2'h0;
		err_total = 0;
		checks = 0;
		void'($urandom(24));
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		`CHK(gate, gate_exp(2'h0));
		`CHK(oldCfgMayLinger, 1'b0);
		rd_chk(`RSC_OFF_CONTROL, 1'b1);
		rd_chk(`RSC_OFF_CONTROL_ACK, 1'b1);
		apb(1'b0, `RSC_OFF_FEATURE_ID, 32'h0000_0000, 1'b1, rd, er);
		`CHK(rd, fid_exp());
		`CHK((`RSC_REALM_BASE + rd[31:22] * `RSC_REALM_STEP) % 32'h0002_0000, 32'h0000_0000);
		apb(1'b0, `RSC_OFF_IMPL_ID, 32'h0000_0000, 1'b1, rd, er);
		`CHK(rd, IID_EXP);
		apb(1'b0, 12'h010, 32'h0000_0000, 1'b1, rd, er);
		`CHK({rd, er}, {32'h0000_0000, 1'b1});
		upd(2'h1, 6'h01);
		upd(2'h3, 6'h20);
		`CHK(oldCfgMayLinger, 1'b0);
		upd(2'h1, 6'h18);
		`CHK(oldCfgMayLinger, 1'b1);
		@(posedge core_clk);
		allPhysInvalDone <= 1'b1;
		@(posedge core_clk);
		allPhysInvalDone <= 1'b0;
		@(posedge core_clk);
		`CHK(oldCfgMayLinger, 1'b0);
		upd(2'h0, 6'h0E);
		for (int i = 0; i < 40; i++)
		begin
			case ($urandom_range(0, 4))
				0: a = `RSC_OFF_FEATURE_ID;
				1: a = `RSC_OFF_IMPL_ID;
				2: a = `RSC_OFF_CONTROL;
				3: a = `RSC_OFF_CONTROL_ACK;
				default: a = 12'($urandom) & 12'hFFC;
			endcase
			root = 1'($urandom);
			wr = ($urandom_range(0, 3) == 0);
			if (wr && a == `RSC_OFF_CONTROL)
				root = 1'b0;
			apb(wr, a, $urandom, root, rd, er);
			if (!wr)
				`CHK(rd, rd_exp(a, root));
			`CHK(er, root && rd_exp(a, 1'b1) === 32'h0000_0000 && a != `RSC_OFF_CONTROL && a != `RSC_OFF_CONTROL_ACK);
			rd_chk(`RSC_OFF_CONTROL, 1'b1);
		end
		`CHK(gate, gate_exp(2'h0));
		print_verdict();
	end

endmodule // rsc_root_ctrl_tb
